/* rtl/debug_request_handshake.sv */
// debug request, acknowledge, comms flags and authentication status logic
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module debug_request_handshake
#(
  parameter int ADDR_W = 32,
  parameter int DRAIN  = debug_request_pkg::DRAIN_CYCLES
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              external_halt_request,
  input  wire logic              invasive_debug_enable,
  input  wire logic              nonsecure_noninvasive_enable,
  input  wire logic              secure_invasive_enable,
  input  wire logic              secure_noninvasive_enable,
  input  wire logic [ADDR_W-1:0] rom_table_base,
  input  wire logic [ADDR_W-1:0] self_offset,
  input  wire logic              accessIdle,
  input  wire logic              coreRxRead,
  input  wire logic              coreTxWrite,
  input  wire logic [31:0]       coreTxData,
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output var  logic [31:0]       regRdData,
  output var  logic              debug_acknowledge,
  output var  logic              debug_entry_done,
  output var  logic              receive_pending,
  output var  logic              transmit_ready,
  output var  logic              haltRequestCore,
  output var  logic              breakpointEnable,
  output var  logic              traceEnable,
  output var  logic [31:0]       coreRxData,
  output var  logic              irq
);

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  debug_request_pkg::halt_state_t state_r;
  debug_request_pkg::halt_state_t state_nxt;
  logic [3:0]            method_r;
  logic                  ackCtl_r;
  logic                  rxFull_r;
  logic                  txFull_r;
  logic [31:0]           inbound_r;
  logic [31:0]           outbound_r;
  logic [3:0]            auth_r;
  logic                  secUser_r;
  logic                  secure_user_invasive_enable_r;
  logic [debug_request_pkg::EVT_WIDTH-1:0] evtStat_r;
  logic [debug_request_pkg::EVT_WIDTH-1:0] evtMask_r;
  logic [debug_request_pkg::EVT_WIDTH-1:0] evtSet;
  logic                  drainDone;
  logic                  haltAllowed;
  logic                  restart;
  logic [31:0]           statusWord;

  // decode a write to one register
  function automatic logic wrHit(input logic [3:0] ofs);
    return regWrite && (regAddr == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // halt gating and entry sequencing
  // ----------------------------------------------------------------------
  // halting events need invasive enable and, in secure user, secure enable
  assign haltAllowed = invasive_debug_enable
                     && !(secUser_r && !secure_invasive_enable);
  // restart strobe; a process, since a continuous assign misses the function's inputs
  always_comb
    restart = wrHit(debug_request_pkg::OFS_CONTROL)
              && regWrData[debug_request_pkg::CTL_RESTART];

  // next state of the entry sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      debug_request_pkg::ST_RUN:
        if (external_halt_request && haltAllowed)
          state_nxt = debug_request_pkg::ST_DRAIN;
      debug_request_pkg::ST_DRAIN:
        if (drainDone)
          state_nxt = debug_request_pkg::ST_HALT;
      debug_request_pkg::ST_HALT:
        if (restart)
          state_nxt = debug_request_pkg::ST_RUN;
      default:
        state_nxt = debug_request_pkg::ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state_r <= debug_request_pkg::ST_RUN;
    else
      state_r <= state_nxt;
  end

  // barrier drain: waits for idle accesses then a fixed window
  entry_drain_counter
  #(
    .COUNT      (DRAIN)
  )
  u_drain
  (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (state_r == debug_request_pkg::ST_RUN
                 && state_nxt == debug_request_pkg::ST_DRAIN),
    .accessIdle (accessIdle),
    .finished   (drainDone)
  );

  // entry method field captured on external entry
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      method_r <= debug_request_pkg::METHOD_NONE;
    else if (state_r == debug_request_pkg::ST_RUN
             && state_nxt == debug_request_pkg::ST_DRAIN)
      method_r <= debug_request_pkg::METHOD_EXTERNAL;
  end

  // outputs of the handshake
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      debug_acknowledge <= 1'b0;
      debug_entry_done  <= 1'b0;
      haltRequestCore   <= 1'b0;
    end
    else
    begin
      debug_acknowledge <= (state_nxt == debug_request_pkg::ST_HALT)
                         || ackCtl_nxt();
      debug_entry_done  <= (state_nxt == debug_request_pkg::ST_HALT);
      haltRequestCore   <= (state_nxt == debug_request_pkg::ST_DRAIN);
    end
  end

  // value the acknowledge control bit takes at the next edge
  function automatic logic ackCtl_nxt();
    if (wrHit(debug_request_pkg::OFS_STATUS))
      return regWrData[debug_request_pkg::STAT_ACKCTL];
    return ackCtl_r;
  endfunction

  // acknowledge control bit
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ackCtl_r <= 1'b0;
    else
      ackCtl_r <= ackCtl_nxt();
  end

  // ----------------------------------------------------------------------
  // communications channel
  // ----------------------------------------------------------------------
  // inbound register: debugger fills, core empties; a fill beats a drain
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rxFull_r  <= 1'b0;
      inbound_r <= 32'h0000_0000;
    end
    else if (wrHit(debug_request_pkg::OFS_INBOUND))
    begin
      rxFull_r  <= 1'b1;
      inbound_r <= regWrData;
    end
    else if (coreRxRead)
      rxFull_r  <= 1'b0;
  end

  // outbound register: core fills, debugger read drains; a fill wins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      txFull_r   <= 1'b0;
      outbound_r <= 32'h0000_0000;
    end
    else if (coreTxWrite)
    begin
      txFull_r   <= 1'b1;
      outbound_r <= coreTxData;
    end
    else if (regRead && regAddr == debug_request_pkg::OFS_OUTBOUND)
      txFull_r   <= 1'b0;
  end

  // channel flags follow the full bits in the same cycle as the status
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      receive_pending <= 1'b0;
      transmit_ready  <= 1'b1;
      coreRxData      <= 32'h0000_0000;
    end
    else
    begin
      receive_pending <= wrHit(debug_request_pkg::OFS_INBOUND)
                       || (rxFull_r && !coreRxRead);
      transmit_ready  <= !(coreTxWrite || (txFull_r
                       && !(regRead && regAddr == debug_request_pkg::OFS_OUTBOUND)));
      coreRxData      <= wrHit(debug_request_pkg::OFS_INBOUND) ? regWrData : inbound_r;
    end
  end

  // ----------------------------------------------------------------------
  // authentication sampling and permissions
  // ----------------------------------------------------------------------
  // re-sample inputs each cycle so polling sees the current combination
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      auth_r           <= 4'h0;
      breakpointEnable <= 1'b0;
      traceEnable      <= 1'b0;
    end
    else
    begin
      auth_r           <= {secure_invasive_enable, invasive_debug_enable,
                           secure_noninvasive_enable, nonsecure_noninvasive_enable};
      breakpointEnable <= invasive_debug_enable
                        && (secure_invasive_enable || !secUser_r);
      traceEnable      <= invasive_debug_enable || nonsecure_noninvasive_enable;
    end
  end

  // core mode and secure user invasive enable from the control register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      secUser_r <= 1'b0;
      secure_user_invasive_enable_r  <= 1'b0;
    end
    else if (wrHit(debug_request_pkg::OFS_CONTROL))
    begin
      secUser_r <= regWrData[debug_request_pkg::CTL_SECUSER];
      secure_user_invasive_enable_r  <= regWrData[debug_request_pkg::CTL_SECURE_USER_INVASIVE_ENABLE];
    end
  end

  // ----------------------------------------------------------------------
  // status word and interrupts
  // ----------------------------------------------------------------------
  // assemble the debug status view
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[debug_request_pkg::STAT_RXFULL] = rxFull_r;
    statusWord[debug_request_pkg::STAT_TXFULL] = txFull_r;
    // non-secure pair: invasive and non-secure non-invasive
    statusWord[debug_request_pkg::STAT_NSAUTH_HI] = auth_r[2];
    statusWord[debug_request_pkg::STAT_NSAUTH_LO] = auth_r[2] | auth_r[0];
    // secure pair reads zero while invasive enable is low
    statusWord[debug_request_pkg::STAT_SAUTH_HI] = auth_r[2] & auth_r[3];
    statusWord[debug_request_pkg::STAT_SAUTH_LO] = auth_r[2] & (auth_r[3] | auth_r[1]);
    statusWord[debug_request_pkg::STAT_ACKCTL] = ackCtl_r;
    statusWord[debug_request_pkg::STAT_METHOD_HI:debug_request_pkg::STAT_METHOD_LO] = method_r;
    statusWord[debug_request_pkg::STAT_HALTED] = (state_r == debug_request_pkg::ST_HALT);
  end

  // events: entered debug, entry done, inbound filled, outbound emptied
  // outbound emptied is the drain itself, so a cleared bit does not re-arm while idle
  always_comb
    evtSet = {txFull_r && !coreTxWrite
                && regRead && regAddr == debug_request_pkg::OFS_OUTBOUND,
              wrHit(debug_request_pkg::OFS_INBOUND),
              drainDone,
              state_r == debug_request_pkg::ST_DRAIN && drainDone};

  // sticky status cleared by a read, a set in the same cycle wins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      evtStat_r <= '0;
    else if (regRead && regAddr == debug_request_pkg::OFS_IRQSTAT)
      evtStat_r <= evtSet;
    else
      evtStat_r <= evtStat_r | evtSet;
  end

  // mask register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      evtMask_r <= '0;
    else if (wrHit(debug_request_pkg::OFS_IRQMASK))
      evtMask_r <= regWrData[debug_request_pkg::EVT_WIDTH-1:0];
  end

  // level interrupt from registered status and mask
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(evtStat_r & evtMask_r);
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      regRdData <= 32'h0000_0000;
    else if (regRead)
    begin
      unique case (regAddr)
        debug_request_pkg::OFS_STATUS:   regRdData <= statusWord;
        debug_request_pkg::OFS_AUTH:     regRdData <= {28'h0, auth_r};
        debug_request_pkg::OFS_INBOUND:  regRdData <= inbound_r;
        debug_request_pkg::OFS_OUTBOUND: regRdData <= outbound_r;
        debug_request_pkg::OFS_ROMBASE:  regRdData <= 32'(rom_table_base);
        debug_request_pkg::OFS_SELFOFS:  regRdData <= 32'(self_offset);
        debug_request_pkg::OFS_IRQSTAT:  regRdData <= {28'h0, evtStat_r};
        debug_request_pkg::OFS_IRQMASK:  regRdData <= {28'h0, evtMask_r};
        debug_request_pkg::OFS_CONTROL:  regRdData <= {29'h0, secure_user_invasive_enable_r, secUser_r, 1'b0};
        default:                         regRdData <= 32'h0000_0000;
      endcase
    end
    else
      regRdData <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

/* rtl/debug_request_pkg.sv */
// package of constants for the debug request handshake block
package debug_request_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_STATUS    = 4'h0; // debug status and control
  localparam logic [3:0] OFS_AUTH      = 4'h1; // authentication status
  localparam logic [3:0] OFS_INBOUND   = 4'h2; // inbound transfer register
  localparam logic [3:0] OFS_OUTBOUND  = 4'h3; // outbound transfer register
  localparam logic [3:0] OFS_ROMBASE   = 4'h4; // rom table base
  localparam logic [3:0] OFS_SELFOFS   = 4'h5; // self offset
  localparam logic [3:0] OFS_IRQSTAT   = 4'h6; // sticky event status
  localparam logic [3:0] OFS_IRQMASK   = 4'h7; // event mask
  localparam logic [3:0] OFS_CONTROL   = 4'h8; // halt restart and core side control

  // debug status field positions
  localparam int STAT_RXFULL     = 30;
  localparam int STAT_TXFULL     = 29;
  localparam int STAT_NSAUTH_HI  = 17;
  localparam int STAT_NSAUTH_LO  = 16;
  localparam int STAT_SAUTH_HI   = 15;
  localparam int STAT_SAUTH_LO   = 14;
  localparam int STAT_ACKCTL     = 10;
  localparam int STAT_METHOD_HI  = 5;
  localparam int STAT_METHOD_LO  = 2;
  localparam int STAT_HALTED     = 0;

  // debug entry method codes
  localparam logic [3:0] METHOD_NONE     = 4'h0;
  localparam logic [3:0] METHOD_EXTERNAL = 4'h4;

  // control register bits
  localparam int CTL_RESTART     = 0; // write 1 leaves debug state
  localparam int CTL_SECUSER     = 1; // core is in secure user mode
  localparam int CTL_SECURE_USER_INVASIVE_ENABLE      = 2; // secure user invasive enable

  // interrupt event bits
  localparam int EVT_HALTED      = 0;
  localparam int EVT_DONE        = 1;
  localparam int EVT_RXFULL      = 2;
  localparam int EVT_TXEMPTY     = 3;
  localparam int EVT_WIDTH       = 4;

  // drain time before entry completes
  localparam int DRAIN_NS        = 300;
  localparam int CLOCK_NS        = 100;
  localparam int DRAIN_CYCLES    = (DRAIN_NS + CLOCK_NS - 1) / CLOCK_NS;

  // handshake state machine, gray codes along the halt path
  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_HALT  = 2'b11
  } halt_state_t;

endpackage

/* rtl/entry_drain_counter.sv */
// counts the drain window before debug entry completes
`timescale 1ns/100ps
`default_nettype none
module entry_drain_counter
#(
  parameter int COUNT = 3
)
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic accessIdle,
  output var  logic finished
);

  logic [7:0] count_r;
  logic       busy_r;

  // counts down once accesses have drained, then flags completion
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count_r  <= 8'h00;
      busy_r   <= 1'b0;
      finished <= 1'b0;
    end
    else if (start)
    begin
      count_r  <= COUNT[7:0];
      busy_r   <= 1'b1;
      finished <= 1'b0;
    end
    else if (busy_r && accessIdle)
    begin
      if (count_r <= 8'h01)
      begin
        busy_r   <= 1'b0;
        finished <= 1'b1;
      end
      else
      begin
        count_r <= count_r - 8'h01;
      end
    end
    else
    begin
      finished <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* dv/debug_request_handshake_monitor.sv */
// assertion checker on the ports of the debug request handshake block
`timescale 1ns/100ps
`default_nettype none
module debug_request_handshake_monitor
#(
  parameter int ADDR_W = 32
)
(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              external_halt_request,
  input wire logic              invasive_debug_enable,
  input wire logic [ADDR_W-1:0] rom_table_base,
  input wire logic              accessIdle,
  input wire logic              coreRxRead,
  input wire logic              coreTxWrite,
  input wire logic [3:0]        regAddr,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [31:0]       regRdData,
  input wire logic              debug_acknowledge,
  input wire logic              debug_entry_done,
  input wire logic              receive_pending,
  input wire logic              transmit_ready,
  input wire logic              haltRequestCore
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // a halt starts only from a request with invasive debug allowed
  halt_cause_a: assert property ($rose(haltRequestCore)
    |-> $past(external_halt_request) && $past(invasive_debug_enable)) else $error("bad halt");
  // entry completes within a bounded drain
  entry_bound_a: assert property ($rose(haltRequestCore)
    |-> ##[1:60] debug_entry_done) else $error("entry late");
  // done only after the core traffic went idle
  done_idle_a: assert property ($rose(debug_entry_done)
    |-> $past(accessIdle) && $past(accessIdle, 2)) else $error("done busy");
  done_ack_a: assert property (debug_entry_done |-> debug_acknowledge)
    else $error("done no ack");
  // comms flags follow the transfer registers
  rx_set_a: assert property (regWrite && regAddr == debug_request_pkg::OFS_INBOUND
    |=> receive_pending) else $error("rx not set");
  rx_clr_a: assert property (coreRxRead && !regWrite |=> !receive_pending)
    else $error("rx not clear");
  tx_clr_a: assert property (coreTxWrite && !regRead |=> !transmit_ready)
    else $error("tx not clear");
  tx_set_a: assert property (regRead && regAddr == debug_request_pkg::OFS_OUTBOUND
    && !coreTxWrite |=> transmit_ready) else $error("tx not set");
  flag_read_a: assert property (regRead && regAddr == debug_request_pkg::OFS_STATUS
    |=> regRdData[30] == $past(receive_pending) && regRdData[29] == !$past(transmit_ready))
    else $error("flag bits");
  rom_read_a: assert property (regRead && regAddr == debug_request_pkg::OFS_ROMBASE
    |=> regRdData == $past(rom_table_base)) else $error("rom base");
endmodule

bind debug_request_handshake debug_request_handshake_monitor #(.ADDR_W(ADDR_W)) mon (.*);
`default_nettype wire

/* dv/debug_controller_model.sv */
// model of the debug controller and of the core's outstanding memory traffic
`timescale 1ns/100ps
`default_nettype none
module debug_controller_model
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire logic [7:0] busyLen,
  input  wire logic       debug_acknowledge,
  output var  logic       external_halt_request,
  output var  logic       accessIdle
);
  logic [7:0] busy_r;

  // request raised by go and held until acknowledge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      external_halt_request <= 1'b0;
    else if (debug_acknowledge)
      external_halt_request <= 1'b0;
    else if (go)
      external_halt_request <= 1'b1;
  end

  // accesses stay outstanding for busyLen cycles after go
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      busy_r <= 8'h00;
    else if (go)
      busy_r <= busyLen;
    else if (busy_r != 8'h00)
      busy_r <= busy_r - 8'h01;
  end
  assign accessIdle = (busy_r == 8'h00);
endmodule
`default_nettype wire

/* dv/debug_request_handshake_tb.sv */
// self-checking bench for the debug request handshake block
`timescale 1ns/100ps
`default_nettype none
module debug_request_handshake_tb;
  logic        clock, sys_rst, go, accessIdle, external_halt_request, irq;
  logic        invasive_debug_enable, nonsecure_noninvasive_enable;
  logic        secure_invasive_enable, secure_noninvasive_enable;
  logic        coreRxRead, coreTxWrite, regWrite, regRead, haltRequestCore;
  logic        debug_acknowledge, debug_entry_done, receive_pending, transmit_ready;
  logic        breakpointEnable, traceEnable;
  logic [31:0] rom_table_base, self_offset, coreTxData, regWrData, regRdData, coreRxData, rv;
  logic [3:0]  regAddr;
  logic [7:0]  busyLen;
  int          numErrors, checked, i;

  debug_request_handshake uut (.*);
  debug_controller_model ctl (.*);

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rv = regRdData;
  endtask

  task automatic request();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask

  task automatic wait_ack(input logic v);
    for (int n = 0; n < 100 && debug_acknowledge !== v; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(debug_acknowledge, v);
    if (debug_acknowledge !== v)
      test_done();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {sys_rst, go, coreRxRead, coreTxWrite, regWrite, regRead} = 6'h20;
    {invasive_debug_enable, nonsecure_noninvasive_enable} = 2'h0;
    {secure_invasive_enable, secure_noninvasive_enable} = 2'h0;
    rom_table_base = 32'h12345000;
    self_offset = 32'h00010000;
    coreTxData = 32'h0000005A;
    regWrData = 32'h0;
    regAddr = 4'h0;
    busyLen = 8'h00;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1 chk({debug_acknowledge, receive_pending, transmit_ready}, 32'h1);
    rd(debug_request_pkg::OFS_ROMBASE);
    chk(rv, 32'h12345000);
    rd(debug_request_pkg::OFS_SELFOFS);
    chk(rv, 32'h00010000);
    // every authentication combination is reported
    for (i = 0; i < 16; i++)
    begin
      {secure_invasive_enable, invasive_debug_enable, secure_noninvasive_enable,
        nonsecure_noninvasive_enable} <= i[3:0];
      repeat (3) @(posedge clock);
      rd(debug_request_pkg::OFS_AUTH);
      chk(rv[3:0], i[3:0]);
      rd(debug_request_pkg::OFS_STATUS);
      if (!i[2])
      begin
        chk({rv[15:14], breakpointEnable}, 3'b000);
        if (!i[0])
          chk(traceEnable, 1'b0);
      end
      else
        chk(rv[17:16], 2'b11);
    end
    chk({breakpointEnable, traceEnable}, 2'b11);
    // halt refused while invasive debug is off, then taken with slow drain
    invasive_debug_enable <= 1'b0;
    busyLen <= 8'h06;
    request();
    repeat (20) @(posedge clock);
    #1 chk({haltRequestCore, debug_acknowledge}, 2'b00);
    invasive_debug_enable <= 1'b1;
    request();
    wait_ack(1'b1);
    chk({debug_entry_done, haltRequestCore}, 2'b10);
    rd(debug_request_pkg::OFS_STATUS);
    chk({rv[5:2], rv[0]}, 5'h09);
    wr(debug_request_pkg::OFS_CONTROL, 32'h1);
    wait_ack(1'b0);
    // fast halt, acknowledge held by the control bit across exit
    busyLen <= 8'h00;
    request();
    wait_ack(1'b1);
    wr(debug_request_pkg::OFS_STATUS, 32'h400);
    wr(debug_request_pkg::OFS_CONTROL, 32'h1);
    repeat (3) @(posedge clock);
    #1 chk({debug_acknowledge, debug_entry_done}, 2'b10);
    wr(debug_request_pkg::OFS_STATUS, 32'h0);
    wait_ack(1'b0);
    // secure user mode blocks halting without secure invasive enable
    wr(debug_request_pkg::OFS_CONTROL, 32'h6);
    rd(debug_request_pkg::OFS_CONTROL);
    chk(rv, 32'h0000_0006);
    secure_invasive_enable <= 1'b0;
    request();
    repeat (20) @(posedge clock);
    #1 chk(debug_acknowledge, 1'b0);
    wr(debug_request_pkg::OFS_CONTROL, 32'h0);
    wait_ack(1'b1);
    wr(debug_request_pkg::OFS_CONTROL, 32'h1);
    wait_ack(1'b0);
    // comms flags with masked and unmasked interrupts
    rd(debug_request_pkg::OFS_IRQSTAT);
    wr(debug_request_pkg::OFS_IRQMASK, 32'h0);
    wr(debug_request_pkg::OFS_INBOUND, 32'h000000A5);
    chk(coreRxData, 32'h0000_00A5);
    chk(receive_pending, 1'b1);
    @(posedge clock);
    #1 chk(irq, 1'b0);
    rd(debug_request_pkg::OFS_IRQSTAT);
    chk(rv, 32'h4);
    wr(debug_request_pkg::OFS_IRQMASK, 32'hF);
    coreRxRead <= 1'b1;
    @(posedge clock);
    coreRxRead <= 1'b0;
    coreTxWrite <= 1'b1;
    @(posedge clock);
    coreTxWrite <= 1'b0;
    #1 chk({receive_pending, transmit_ready}, 2'b00);
    rd(debug_request_pkg::OFS_OUTBOUND);
    chk(rv, 32'h0000_005A);
    chk(transmit_ready, 1'b1);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b1);
    rd(debug_request_pkg::OFS_IRQSTAT);
    chk(rv, 32'h8);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b0);
    rd(4'hF);
    chk(rv, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
